// *** hw/flash_block_protect_decoder.v ***
// How it works
// - plain mode: zero low code protects nothing; codes 11xx and 1011 protect all.
// - plain mode, top bit clear: code n protects the top 2^(n-1) blocks.
// - plain mode, top bit set: code n protects the bottom 2^(n-1) blocks.
// - complement mode inverts the range, so a zero code protects everything.
// - end blocks keep persistent and temporary locks per 4KB sector.
// - middle blocks keep one persistent and one temporary lock each.
// - range is computed from all five protect bits and complement, ignoring don't-cares.
// - a target is protected if range, temporary or persistent lock says so.
// - lock byte 00 means unlocked, FF locked, other values are ignored.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_map.vh"

module flash_block_protect_decoder #(
  parameter [0:0] TEMP_DEFAULT = 1'b0,
  parameter LOCK_ENTRIES = 1054
) (
  input wire mclk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire op_req,
  input wire [1:0] op_kind,
  input wire [25:0] op_addr,
  output reg op_done,
  output reg op_refused,
  output reg array_we,
  output reg [1:0] array_kind,
  output reg [25:0] array_addr
);

  reg [5:0] protect_q;
  reg [5:0] protect_d;
  reg [10:0] lock_index_q;
  reg [10:0] lock_index_d;
  reg last_refused_q;
  reg last_refused_d;
  reg [15:0] refuse_count_q;
  reg [15:0] refuse_count_d;
  reg [31:0] rdata_d;
  reg done_d;
  reg refused_d;
  reg we_d;
  reg [1:0] kind_d;
  reg [25:0] addr_d;

  reg lock_wr_en;
  reg lock_wr_persist;
  reg lock_wr_value;
  reg temp_clr_all;
  reg temp_set_all;
  reg persist_clr_all;
  reg blocked;
  reg lock_byte_on;
  reg lock_byte_off;
  reg range_hit;
  reg lock_hit;
  reg [31:0] status_word;
  reg [7:0] temp_byte;
  reg [7:0] persist_byte;

  wire rd_temp;
  wire rd_persist;
  wire chk_locked;
  wire chk_block_locked;
  wire any_locked;
  wire in_range;
  wire any_range;

  range_decoder u_range (
    .protect_field(protect_q[`PROTECT_FIELD_MSB:`PROTECT_FIELD_LSB]),
    .complement_select(protect_q[`PROTECT_CMP_BIT]),
    .block(op_addr[25:16]),
    .in_range(in_range),
    .any_range(any_range)
  );

  lock_store #(
    .TEMP_DEFAULT(TEMP_DEFAULT),
    .COUNT(LOCK_ENTRIES)
  ) u_locks (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(lock_wr_en),
    .wr_persist(lock_wr_persist),
    .wr_value(lock_wr_value),
    .wr_index(lock_index_q),
    .temp_clr_all(temp_clr_all),
    .temp_set_all(temp_set_all),
    .persist_clr_all(persist_clr_all),
    .rd_index(lock_index_q),
    .rd_temp(rd_temp),
    .rd_persist(rd_persist),
    .chk_addr(op_addr),
    .chk_locked(chk_locked),
    .chk_block_locked(chk_block_locked),
    .any_locked(any_locked)
  );

  // lock byte decode, anything but 00 or FF is dropped
  always @* begin
    lock_byte_on = (reg_wdata[7:0] == `LOCK_BYTE_ON);
    lock_byte_off = (reg_wdata[7:0] == `LOCK_BYTE_OFF);
  end

  // protect and index register writes
  always @* begin
    protect_d = protect_q;
    lock_index_d = lock_index_q;
    if (reg_wr) begin
      case (reg_addr)
        `REG_PROTECT: begin
          protect_d = reg_wdata[5:0];
        end
        `REG_LOCK_INDEX: begin
          lock_index_d = reg_wdata[10:0];
        end
        default: begin
          protect_d = protect_q;
        end
      endcase
    end
  end

  // single-entry lock writes
  always @* begin
    lock_wr_en = 1'b0;
    lock_wr_persist = 1'b0;
    lock_wr_value = 1'b0;
    if (reg_wr && (reg_addr == `REG_TEMP_LOCK || reg_addr == `REG_PERSIST_LOCK)) begin
      lock_wr_persist = (reg_addr == `REG_PERSIST_LOCK);
      lock_wr_value = lock_byte_on;
      lock_wr_en = lock_byte_on | lock_byte_off;
    end
  end

  // global lock commands, unlock wins over lock
  always @* begin
    temp_clr_all = 1'b0;
    temp_set_all = 1'b0;
    persist_clr_all = 1'b0;
    if (reg_wr && reg_addr == `REG_GLOBAL) begin
      temp_clr_all = reg_wdata[`GLOBAL_TEMP_UNLOCK_BIT];
      temp_set_all = reg_wdata[`GLOBAL_TEMP_LOCK_BIT] & ~reg_wdata[`GLOBAL_TEMP_UNLOCK_BIT];
      persist_clr_all = reg_wdata[`GLOBAL_PERSIST_CLEAR_BIT];
    end
  end

  // range side of the verdict
  always @* begin
    case (op_kind)
      `OP_CHIP_ERASE: begin
        range_hit = any_range;
      end
      default: begin
        range_hit = in_range;
      end
    endcase
  end

  // lock side of the verdict
  always @* begin
    case (op_kind)
      `OP_BLOCK_ERASE: begin
        lock_hit = chk_block_locked;
      end
      `OP_CHIP_ERASE: begin
        lock_hit = any_locked;
      end
      default: begin
        lock_hit = chk_locked;
      end
    endcase
  end

  // protected when any scheme says so
  always @* begin
    blocked = range_hit | lock_hit;
  end

  // answer pulses one cycle after each request
  always @* begin
    done_d = op_req;
    refused_d = op_req & blocked;
    we_d = op_req & ~blocked;
  end

  // target of the last request, held until the next one
  always @* begin
    kind_d = op_req ? op_kind : array_kind;
    addr_d = op_req ? op_addr : array_addr;
  end

  // last verdict and saturating refusal count
  always @* begin
    last_refused_d = op_req ? blocked : last_refused_q;
    refuse_count_d = refuse_count_q;
    if (op_req && blocked && refuse_count_q != `REFUSE_COUNT_MAX) begin
      refuse_count_d = refuse_count_q + 16'h0001;
    end
  end

  // status word
  always @* begin
    status_word = 32'h00000000;
    status_word[`STATUS_LAST_REFUSED_BIT] = last_refused_q;
    status_word[`STATUS_ANY_RANGE_BIT] = any_range;
    status_word[`STATUS_TEMP_DEFAULT_BIT] = TEMP_DEFAULT;
  end

  // lock state shown as whole bytes
  always @* begin
    temp_byte = rd_temp ? `LOCK_BYTE_ON : `LOCK_BYTE_OFF;
    persist_byte = rd_persist ? `LOCK_BYTE_ON : `LOCK_BYTE_OFF;
  end

  // read data, valid in the cycle after the read strobe only
  always @* begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_PROTECT: begin
          rdata_d = {26'h0000000, protect_q};
        end
        `REG_LOCK_INDEX: begin
          rdata_d = {21'h000000, lock_index_q};
        end
        `REG_TEMP_LOCK: begin
          rdata_d = {24'h000000, temp_byte};
        end
        `REG_PERSIST_LOCK: begin
          rdata_d = {24'h000000, persist_byte};
        end
        `REG_STATUS: begin
          rdata_d = status_word;
        end
        `REG_REFUSE_COUNT: begin
          rdata_d = {16'h0000, refuse_count_q};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // protect and index registers
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      protect_q <= `PROTECT_RESET;
      lock_index_q <= `LOCK_INDEX_RESET;
    end else begin
      protect_q <= protect_d;
      lock_index_q <= lock_index_d;
    end
  end

  // refusal bookkeeping
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_refused_q <= 1'b0;
      refuse_count_q <= `REFUSE_COUNT_RESET;
    end else begin
      last_refused_q <= last_refused_d;
      refuse_count_q <= refuse_count_d;
    end
  end

  // read data, zero unless a read was taken the cycle before
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // answer pulses
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op_done <= 1'b0;
      op_refused <= 1'b0;
      array_we <= 1'b0;
    end else begin
      op_done <= done_d;
      op_refused <= refused_d;
      array_we <= we_d;
    end
  end

  // target of the last request
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      array_kind <= 2'h0;
      array_addr <= 26'h0000000;
    end else begin
      array_kind <= kind_d;
      array_addr <= addr_d;
    end
  end

endmodule // flash_block_protect_decoder

`default_nettype wire

// *** shared/flash_protect_map.vh ***
`ifndef FLASH_PROTECT_MAP_VH
`define FLASH_PROTECT_MAP_VH

// register byte offsets
`define REG_PROTECT 8'h00
`define REG_LOCK_INDEX 8'h04
`define REG_TEMP_LOCK 8'h08
`define REG_PERSIST_LOCK 8'h0C
`define REG_STATUS 8'h10
`define REG_REFUSE_COUNT 8'h14
`define REG_GLOBAL 8'h18

// protect register fields
`define PROTECT_FIELD_LSB 0
`define PROTECT_FIELD_MSB 4
`define PROTECT_CMP_BIT 5
`define PROTECT_RESET 6'h00

// global command bits (write-only, self clearing)
`define GLOBAL_TEMP_UNLOCK_BIT 0
`define GLOBAL_TEMP_LOCK_BIT 1
`define GLOBAL_PERSIST_CLEAR_BIT 2

// status bits
`define STATUS_LAST_REFUSED_BIT 0
`define STATUS_ANY_RANGE_BIT 1
`define STATUS_TEMP_DEFAULT_BIT 2

// lock byte encodings
`define LOCK_BYTE_ON 8'hFF
`define LOCK_BYTE_OFF 8'h00

// lock entry map
`define LOCK_COUNT 11'h41E
`define LOCK_MID_OFFSET 11'h00F
`define LOCK_TOP_BASE 11'h40E
`define LAST_BLOCK 10'h3FF
`define FIRST_BLOCK 10'h000
`define LOCK_INDEX_RESET 11'h000

// refusal counter
`define REFUSE_COUNT_RESET 16'h0000
`define REFUSE_COUNT_MAX 16'hFFFF

// array operation kinds
`define OP_PROGRAM 2'h0
`define OP_SECTOR_ERASE 2'h1
`define OP_BLOCK_ERASE 2'h2
`define OP_CHIP_ERASE 2'h3

`endif

// *** hw/range_decoder.v ***
`timescale 1ns/1ps
`default_nettype none

module range_decoder (
  input wire [4:0] protect_field,
  input wire complement_select,
  input wire [9:0] block,
  output reg in_range,
  output reg any_range
);

  reg [3:0] low;
  reg all_code;
  reg base;
  reg [10:0] span;
  reg [10:0] blk_ext;

  always @* begin
    low = protect_field[3:0];
    all_code = (low[3:2] == 2'h3) || (low == 4'hB);
    blk_ext = {1'b0, block};
    span = 11'h001;
    base = 1'b0;
    if (low == 4'h0) begin
      base = 1'b0;
    end else if (all_code) begin
      base = 1'b1;
    end else begin
      span = 11'h001 << (low - 4'h1);
      if (protect_field[4]) begin
        base = blk_ext < span;
      end else begin
        base = blk_ext >= (11'h400 - span);
      end
    end
    in_range = base ^ complement_select;
    any_range = complement_select ? !all_code : (low != 4'h0);
  end

endmodule // range_decoder

`default_nettype wire

// *** hw/lock_store.v ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_map.vh"

module lock_store #(
  parameter [0:0] TEMP_DEFAULT = 1'b0,
  parameter COUNT = 1054
) (
  input wire mclk,
  input wire nrst,
  input wire wr_en,
  input wire wr_persist,
  input wire wr_value,
  input wire [10:0] wr_index,
  input wire temp_clr_all,
  input wire temp_set_all,
  input wire persist_clr_all,
  input wire [10:0] rd_index,
  output wire rd_temp,
  output wire rd_persist,
  input wire [25:0] chk_addr,
  output reg chk_locked,
  output reg chk_block_locked,
  output wire any_locked
);

  reg [COUNT-1:0] temp_q;
  reg [COUNT-1:0] persist_q;
  reg [10:0] chk_index;
  reg [9:0] chk_blk;
  reg [15:0] edge_temp;
  reg [15:0] edge_persist;
  reg [10:0] edge_base;

  genvar i;
  generate
    for (i = 0; i < COUNT; i = i + 1) begin : entry
      localparam [10:0] IDX = i;
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          temp_q[i] <= TEMP_DEFAULT;
          persist_q[i] <= 1'b0;
        end else begin
          if (temp_clr_all) begin
            temp_q[i] <= 1'b0;
          end else if (temp_set_all) begin
            temp_q[i] <= 1'b1;
          end else if (wr_en && !wr_persist && wr_index == IDX) begin
            temp_q[i] <= wr_value;
          end
          if (persist_clr_all) begin
            persist_q[i] <= 1'b0;
          end else if (wr_en && wr_persist && wr_index == IDX) begin
            persist_q[i] <= wr_value;
          end
        end
      end
    end
  endgenerate

  assign rd_temp = (rd_index < `LOCK_COUNT) ? temp_q[rd_index] : 1'b0;
  assign rd_persist = (rd_index < `LOCK_COUNT) ? persist_q[rd_index] : 1'b0;
  assign any_locked = (|temp_q) | (|persist_q);

  // sector entries in the end blocks, block entries between them
  always @* begin
    chk_blk = chk_addr[25:16];
    if (chk_blk == `FIRST_BLOCK) begin
      chk_index = {7'h00, chk_addr[15:12]};
      edge_base = 11'h000;
    end else if (chk_blk == `LAST_BLOCK) begin
      chk_index = `LOCK_TOP_BASE + {7'h00, chk_addr[15:12]};
      edge_base = `LOCK_TOP_BASE;
    end else begin
      chk_index = {1'b0, chk_blk} + `LOCK_MID_OFFSET;
      edge_base = 11'h000;
    end
    chk_locked = temp_q[chk_index] | persist_q[chk_index];
    edge_temp = temp_q[edge_base +: 16];
    edge_persist = persist_q[edge_base +: 16];
    if (chk_blk == `FIRST_BLOCK || chk_blk == `LAST_BLOCK) begin
      chk_block_locked = (|edge_temp) | (|edge_persist);
    end else begin
      chk_block_locked = chk_locked;
    end
  end

endmodule // lock_store

`default_nettype wire

// *** dv/protect_checker_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_map.vh"
module protect_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic op_req,
  input wire logic [1:0] op_kind,
  input wire logic [25:0] op_addr,
  input wire logic op_done,
  input wire logic op_refused,
  input wire logic array_we,
  input wire logic [1:0] array_kind,
  input wire logic [25:0] array_addr
);
  logic [5:0] prot_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      prot_q <= 6'h00;
    else if (reg_wr && reg_addr == `REG_PROTECT)
      prot_q <= reg_wdata[5:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_done_after_req:
    assert property (op_req |=> op_done) else $error("no done after request");
  chk_done_cause:
    assert property (op_done |-> $past(op_req)) else $error("done without request");
  chk_one_answer:
    assert property (op_done |-> op_refused != array_we) else $error("refuse and write disagree");
  chk_quiet_idle:
    assert property (!op_done |-> !op_refused && !array_we) else $error("pulse without done");
  chk_target_capture:
    assert property (op_req |=> array_addr == $past(op_addr) && array_kind == $past(op_kind)) else $error("target");
  chk_target_hold:
    assert property (!op_req |=> $stable(array_addr)) else $error("target moved");
  chk_full_range:
    assert property (op_req && !prot_q[5] && (prot_q[3:2] == 2'h3 || prot_q[3:0] == 4'hB) |=> op_refused)
      else $error("full range not refused");
  chk_cmp_zero:
    assert property (op_req && prot_q[5] && prot_q[3:0] == 4'h0 |=> op_refused) else $error("cmp zero not refused");
  chk_protect_read:
    assert property (reg_rd && reg_addr == `REG_PROTECT |=> reg_rdata == {26'h0, $past(prot_q)}) else $error("readback");
endmodule // protect_checker
bind flash_block_protect_decoder protect_checker u_chk (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_req(op_req),
  .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done), .op_refused(op_refused), .array_we(array_we),
  .array_kind(array_kind), .array_addr(array_addr));
`default_nettype wire

// *** dv/flash_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input wire logic mclk,
  input wire logic op_done,
  input wire logic op_refused,
  input wire logic array_we,
  output logic op_req,
  output logic [1:0] op_kind,
  output logic [25:0] op_addr
);
  initial begin
    op_req = 1'b0;
    op_kind = 2'h0;
    op_addr = 26'h0;
  end
  task automatic issue(input logic [1:0] k, input logic [25:0] a, output logic [2:0] r);
    @(posedge mclk);
    op_req <= 1'b1;
    op_kind <= k;
    op_addr <= a;
    @(posedge mclk);
    op_req <= 1'b0;
    // released lines show no stale value
    op_kind <= ~k;
    op_addr <= ~a;
    #1 r = {op_done, op_refused, array_we};
  endtask
endmodule // flash_host_model
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_map.vh"
module tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic op_req, op_done, op_refused, array_we;
  wire logic [1:0] op_kind;
  wire logic [25:0] op_addr;
  int bad_count = 0;
  int checks = 0;
  int unsigned seed = 74;
  int blk[8] = '{0, 1, 511, 512, 767, 768, 1022, 1023};
  bit tl[1054];
  bit pl[1054];
  logic [5:0] pr = 6'h00;
  int rc = 0;
  bit lr = 1'b0;
  always #50 mclk = ~mclk;
  flash_block_protect_decoder u_flash_block_protect_decoder (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_req(op_req),
    .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done), .op_refused(op_refused), .array_we(array_we),
    .array_kind(), .array_addr());
  flash_host_model u_flash_host_model (.mclk(mclk), .op_done(op_done), .op_refused(op_refused),
    .array_we(array_we), .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit inr(int b);
    int n = pr[3:0];
    int c = 1 << (n - 1);
    bit p = (n >= 11) ? 1'b1 : (n == 0) ? 1'b0 : pr[4] ? b < c : b >= 1024 - c;
    return p ^ pr[5];
  endfunction
  function automatic int ix(logic [25:0] a);
    int b = a[25:16];
    return b == 0 ? a[15:12] : b == 1023 ? 1038 + a[15:12] : b + 15;
  endfunction
  function automatic logic [25:0] ad(int i);
    return 26'(i < 16 ? i << 12 : i < 1038 ? (i - 15) << 16 : 32'h3FF0000 | ((i - 1038) << 12));
  endfunction
  function automatic bit anyr();
    bit p = 1'b0;
    for (int j = 0; j < 1024; j++)
      p |= inr(j);
    return p;
  endfunction
  function automatic bit prot(logic [1:0] k, logic [25:0] a);
    int b = a[25:16];
    bit p = (k != 2'h3) && (inr(b) || tl[ix(a)] || pl[ix(a)]);
    for (int i = 0; i < 1054; i++)
      p |= (tl[i] || pl[i]) && (k == 2'h3 || k == 2'h2 && (i < 16 ? b == 0 : i >= 1038 && b == 1023));
    p |= k == 2'h3 && anyr();
    return p;
  endfunction
  task automatic cmp_op(logic [2:0] g, logic [2:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp(logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask
  task automatic op(logic [1:0] k, logic [25:0] a);
    logic [2:0] r;
    bit p;
    p = prot(k, a);
    u_flash_host_model.issue(k, a, r);
    cmp_op(r, {1'b1, p, !p});
    rc = rc + p;
    lr = p;
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    int i;
    bit per;
    logic [7:0] d;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    rd(`REG_PROTECT, 32'h0);
    rd(8'hFC, 32'h0);
    for (int v = 0; v < 64; v++) begin
      wr(`REG_PROTECT, v);
      pr = 6'(v);
      rd(`REG_PROTECT, v);
      foreach (blk[j])
        op(2'(rnd() & 1), {10'(blk[j]), 16'(rnd())});
      op(2'h2, 26'(rnd()));
      op(2'h3, 26'(rnd()));
      rd(`REG_STATUS, {29'h0, 1'b0, anyr(), lr});
    end
    wr(`REG_PROTECT, 32'h0);
    pr = 6'h00;
    for (int t = 0; t < 60; t++) begin
      i = rnd() % 1054;
      per = rnd() & 1;
      d = t % 3 == 2 ? 8'(rnd()) : {8{1'(rnd())}};
      wr(`REG_LOCK_INDEX, i);
      wr(per ? `REG_PERSIST_LOCK : `REG_TEMP_LOCK, d);
      if (d == `LOCK_BYTE_ON || d == `LOCK_BYTE_OFF) begin
        if (per)
          pl[i] = d[0];
        else
          tl[i] = d[0];
      end
      rd(per ? `REG_PERSIST_LOCK : `REG_TEMP_LOCK, {24'h0, {8{per ? pl[i] : tl[i]}}});
      op(2'(rnd()), ad(i) | 26'(12'(rnd())));
      op(2'(rnd() & 1), ad((i + 1) % 1054));
    end
    wr(`REG_GLOBAL, 32'h5);
    tl = '{default: 0};
    pl = '{default: 0};
    op(2'h3, 26'h0);
    wr(`REG_GLOBAL, 32'h2);
    tl = '{default: 1};
    op(2'h0, 26'(rnd()));
    wr(`REG_LOCK_INDEX, 32'h7FF);
    rd(`REG_LOCK_INDEX, 32'h7FF);
    rd(`REG_TEMP_LOCK, 32'h0);
    wr(`REG_GLOBAL, 32'h3);
    tl = '{default: 0};
    op(2'h3, 26'(rnd()));
    rd(`REG_REFUSE_COUNT, rc);
    rd(`REG_STATUS, {29'h0, 1'b0, anyr(), lr});
    print_verdict();
  end
  initial begin
    #1000000;
    bad_count++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
